// ==== include/lcc_pkg.sv ====
// shared constants and types for the programmable logic cell
package lcc_pkg;
    // operating modes
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_ARITH,
        MODE_UPDOWN,
        MODE_CLRCNT
    } lcc_mode_type;
    // storage element personalities
    typedef enum logic [1:0] {
        FF_D,
        FF_T,
        FF_JK,
        FF_SR
    } lcc_ff_type;
    // output source select
    typedef enum logic [1:0] {
        OUT_LUT,
        OUT_REG,
        OUT_CASCADE
    } lcc_outsel_type;
    // clear/preset personalities
    typedef enum logic [2:0] {
        CP_CLEAR,
        CP_PRESET,
        CP_CLEAR_PRESET,
        CP_LOAD_CLEAR,
        CP_LOAD_PRESET,
        CP_LOAD_ONLY
    } lcc_cpmode_type;
    // control source select (global, pin, internal logic)
    typedef enum logic [1:0] {
        SRC_GLOBAL,
        SRC_PIN,
        SRC_LOGIC
    } lcc_src_type;
    localparam int LUT_INPUTS = 4;
    localparam int LUT_SIZE = 16;
    localparam int CELLS_PER_CLUSTER = 8;
    localparam int INPUTS_PER_CASCADE_CELL = 4;
    localparam logic [15:0] LUT_RESET = 16'h0000;
    localparam logic REG_RESET = 1'b0;
    localparam logic [15:0] ARITH_SUM_DEFAULT = 16'h9696;
    localparam logic [15:0] ARITH_CARRY_DEFAULT = 16'he8e8;
    // chains stop at the ram block in mid row
    localparam int RAM_SPLIT_CLUSTER = 18;
    // next cluster along a long chain keeps the same parity
    // a hop over the ram block ends the chain, -1 means start a new one
    function automatic int lcc_next_cluster(input int cluster);
        if (cluster <= RAM_SPLIT_CLUSTER && cluster + 2 > RAM_SPLIT_CLUSTER) begin
            return -1;
        end else begin
            return cluster + 2;
        end
    endfunction : lcc_next_cluster
endpackage : lcc_pkg

// ==== hdl/lcc_lut4.sv ====
// four-input lookup table, splittable into two three-input tables
`timescale 1ns/1ns
module lcc_lut4
    import lcc_pkg::*;
(
    // table contents
    input wire logic [15:0] table4,
    input wire logic split,
    // selects
    input wire logic [3:0] sel,
    // results
    output logic full,
    output logic lowHalf,
    output logic highHalf
);
    always_comb begin
        full = table4[sel];
        // split mode: lower eight entries make the sum, upper eight the carry
        lowHalf = table4[{1'b0, sel[2:0]}];
        highHalf = split ? table4[{1'b1, sel[2:0]}] : table4[sel];
    end
endmodule : lcc_lut4

// ==== hdl/lcc_ctrl_sel.sv ====
// picks global, pin or internal source for one flip-flop control
`timescale 1ns/1ns
module lcc_ctrl_sel
    import lcc_pkg::*;
(
    // selection
    input wire lcc_src_type src,
    input wire logic invert,
    // candidates
    input wire logic fromGlobal,
    input wire logic fromPin,
    input wire logic fromLogic,
    // chosen control
    output logic ctrl
);
    logic pick;
    always_comb begin
        case (src)
            SRC_GLOBAL: pick = fromGlobal;
            SRC_PIN: pick = fromPin;
            SRC_LOGIC: pick = fromLogic;
            default: pick = 1'b0;
        endcase
        ctrl = pick ^ invert;
    end
endmodule : lcc_ctrl_sel

// ==== hdl/lcc_logic_cell.sv ====
// programmable logic cell: lookup table, flip-flop, carry and cascade chains
`timescale 1ns/1ns
// Functional notes
// - four-input table makes any function
// - storage acts as D, T, JK, SR
// - combinational use bypasses the flip-flop
// - local and global outputs selected independently
// - table and flip-flop drive different outputs
// - carry-in feeds table and carry chain
// - long carry chain links same-parity clusters
// - carry chain stops at mid-row ram
// - n-bit adder uses n plus one cells
// - adder sum bypassed or registered accumulator
// - cascade joins tables by AND or OR
// - each cascade cell adds four inputs
// - long cascade same parity, breaks mid-row
// - four modes: normal, arithmetic, two counters
// - seven logic inputs routed per mode
// - clock, clear, preset are separate inputs
// - synchronous clock enable from first data input
// - controls from global, pin or logic
// - arithmetic splits table into two halves
// - chip-wide reset overrides all controls
module lcc_logic_cell
    import lcc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // configuration
    input wire lcc_mode_type mode,
    input wire lcc_ff_type ffKind,
    input wire lcc_cpmode_type cpMode,
    input wire logic [15:0] lutTable,
    input wire lcc_outsel_type localSel,
    input wire lcc_outsel_type globalSel,
    input wire logic useCarryIn,
    input wire logic useCascade,
    input wire logic cascadeOr,
    input wire logic packedReg,
    input wire logic enableFromData,
    input wire logic chipResetEnable,
    // control source selection
    input wire lcc_src_type clearSrc,
    input wire lcc_src_type presetSrc,
    input wire lcc_src_type enableSrc,
    input wire logic clearInvert,
    input wire logic presetInvert,
    // control candidates, from pins or other domains
    input wire logic globalClear,
    input wire logic globalPreset,
    input wire logic globalEnable,
    input wire logic pinClear,
    input wire logic pinPreset,
    input wire logic pinEnable,
    input wire logic logicClear,
    input wire logic logicPreset,
    input wire logic logicEnable,
    input wire logic chipReset,
    // data inputs
    input wire logic firstDataInput,
    input wire logic secondDataInput,
    input wire logic thirdDataInput,
    input wire logic fourthDataInput,
    // chains in
    input wire logic carryIn,
    input wire logic cascadeIn,
    // outputs
    output logic localOut,
    output logic globalOut,
    output logic carryOut,
    output logic cascadeOut,
    output logic regState
);
    // pin-facing controls pass two flops before use
    logic [2:0] pinMeta;
    logic [2:0] pinSync;
    logic [2:0] next_pinMeta;
    logic [2:0] next_pinSync;
    logic chipMeta;
    logic chipSync;
    logic next_chipMeta;
    logic next_chipSync;

    always_comb begin
        next_pinMeta = {pinEnable, pinPreset, pinClear};
        next_pinSync = pinMeta;
        next_chipMeta = chipReset;
        next_chipSync = chipMeta;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pinMeta <= 3'h0;
            pinSync <= 3'h0;
            chipMeta <= 1'b0;
            chipSync <= 1'b0;
        end else begin
            pinMeta <= next_pinMeta;
            pinSync <= next_pinSync;
            chipMeta <= next_chipMeta;
            chipSync <= next_chipSync;
        end
    end

    // control selection, separate from the seven logic inputs
    logic clearCtrl;
    logic presetCtrl;
    logic enableCtrl;

    lcc_ctrl_sel clearPick (
        .src(clearSrc),
        .invert(clearInvert),
        .fromGlobal(globalClear),
        .fromPin(pinSync[0]),
        .fromLogic(logicClear),
        .ctrl(clearCtrl)
    );

    lcc_ctrl_sel presetPick (
        .src(presetSrc),
        .invert(presetInvert),
        .fromGlobal(globalPreset),
        .fromPin(pinSync[1]),
        .fromLogic(logicPreset),
        .ctrl(presetCtrl)
    );

    lcc_ctrl_sel enablePick (
        .src(enableSrc),
        .invert(1'b0),
        .fromGlobal(globalEnable),
        .fromPin(pinSync[2]),
        .fromLogic(logicEnable),
        .ctrl(enableCtrl)
    );

    // table input routing per mode
    logic [3:0] lutSel;
    logic lutFull;
    logic lutLow;
    logic lutHigh;
    logic splitTable;
    logic regQ;

    always_comb begin
        splitTable = (mode != MODE_NORMAL);
        case (mode)
            MODE_NORMAL: begin
                // carry-in may stand in for the third data input
                lutSel = {fourthDataInput, useCarryIn ? carryIn : thirdDataInput,
                          secondDataInput, firstDataInput};
            end
            MODE_ARITH: begin
                lutSel = {1'b0, carryIn, secondDataInput, firstDataInput};
            end
            MODE_UPDOWN: begin
                // register feedback, direction and carry drive the counter table
                lutSel = {1'b0, carryIn, secondDataInput, regQ};
            end
            MODE_CLRCNT: begin
                lutSel = {1'b0, carryIn, 1'b1, regQ};
            end
            default: begin
                lutSel = 4'h0;
            end
        endcase
    end

    lcc_lut4 table0 (
        .table4(lutTable),
        .split(splitTable),
        .sel(lutSel),
        .full(lutFull),
        .lowHalf(lutLow),
        .highHalf(lutHigh)
    );

    // function result, carry and cascade
    logic lutResult;
    logic cascadeResult;
    logic next_carryOut;
    logic next_cascadeOut;

    always_comb begin
        lutResult = splitTable ? lutLow : lutFull;
        // the carry leaves from the upper table half only in split modes
        next_carryOut = splitTable ? lutHigh : carryIn;
        // or form via de morgan: invert both sides, and, invert back
        if (!useCascade || (packedReg && mode == MODE_NORMAL) || mode == MODE_CLRCNT) begin
            cascadeResult = lutResult;
        end else if (cascadeOr) begin
            cascadeResult = ~(~lutResult & ~cascadeIn);
        end else begin
            cascadeResult = lutResult & cascadeIn;
        end
        next_cascadeOut = cascadeResult;
    end

    // flip-flop next value
    logic dataIn;
    logic syncClear;
    logic enable;
    logic loadValue;
    logic next_regQ;

    always_comb begin
        // packed register takes the fourth input directly
        dataIn = (packedReg && mode == MODE_NORMAL) ? fourthDataInput : cascadeResult;
        syncClear = (mode == MODE_CLRCNT) && !cascadeIn;
        // first data input gates updates on clock edges
        enable = enableFromData ? firstDataInput : enableCtrl;
        loadValue = thirdDataInput;
        next_regQ = regQ;
        if (enable) begin
            if (mode == MODE_UPDOWN || mode == MODE_CLRCNT) begin
                // synchronous load through the two-to-one mux
                next_regQ = fourthDataInput ? loadValue : lutResult;
                if (syncClear) begin
                    next_regQ = 1'b0;
                end
            end else begin
                case (ffKind)
                    FF_D: next_regQ = dataIn;
                    FF_T: next_regQ = dataIn ? ~regQ : regQ;
                    FF_JK: next_regQ = (dataIn & ~regQ) | (~secondDataInput & regQ);
                    FF_SR: next_regQ = dataIn ? 1'b1 : (secondDataInput ? 1'b0 : regQ);
                    default: next_regQ = regQ;
                endcase
            end
        end
        // clear and preset act whatever the enable says
        case (cpMode)
            CP_CLEAR: begin
                if (clearCtrl) next_regQ = 1'b0;
            end
            CP_PRESET: begin
                if (presetCtrl) next_regQ = 1'b1;
            end
            CP_CLEAR_PRESET: begin
                if (clearCtrl) next_regQ = 1'b0;
                else if (presetCtrl) next_regQ = 1'b1;
            end
            CP_LOAD_CLEAR: begin
                if (clearCtrl) next_regQ = 1'b0;
                else if (presetCtrl) next_regQ = thirdDataInput;
            end
            CP_LOAD_PRESET: begin
                if (clearCtrl) next_regQ = 1'b1;
                else if (presetCtrl) next_regQ = thirdDataInput;
            end
            CP_LOAD_ONLY: begin
                if (presetCtrl) next_regQ = thirdDataInput;
            end
            default: begin
                next_regQ = next_regQ;
            end
        endcase
        // chip-wide reset beats every other control
        if (chipResetEnable && chipSync) begin
            next_regQ = REG_RESET;
        end
    end

    // output source selection
    logic next_localOut;
    logic next_globalOut;

    function automatic logic pick_out(input lcc_outsel_type sel, input logic lutVal,
                                      input logic regVal, input logic casVal);
        case (sel)
            OUT_LUT: return lutVal;
            OUT_REG: return regVal;
            OUT_CASCADE: return casVal;
            default: return lutVal;
        endcase
    endfunction : pick_out

    always_comb begin
        // bypass sends the table straight out; sum or accumulator
        next_localOut = pick_out(localSel, lutResult, next_regQ, cascadeResult);
        next_globalOut = pick_out(globalSel, lutResult, next_regQ, cascadeResult);
    end

    // outputs come from flops, so a bypass path adds one cycle of latency
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            regQ <= REG_RESET;
            localOut <= 1'b0;
            globalOut <= 1'b0;
            carryOut <= 1'b0;
            cascadeOut <= 1'b0;
            regState <= REG_RESET;
        end else begin
            regQ <= next_regQ;
            localOut <= next_localOut;
            globalOut <= next_globalOut;
            carryOut <= next_carryOut;
            cascadeOut <= next_cascadeOut;
            regState <= next_regQ;
        end
    end
    // chain linking across clusters is placement, see lcc_next_cluster
endmodule : lcc_logic_cell

// ==== verification/lcc_neighbour_model.sv ====
// lower-order neighbour cell: carry, cascade and control logic
`timescale 1ns/1ns
module lcc_neighbour_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // values to present after the next edge
    input wire logic [2:0] nextLink,
    // toward the cell
    output logic carryIn,
    output logic cascadeIn,
    output logic logicEnable
);
    initial {carryIn, cascadeIn, logicEnable} = 3'h0;
    // registered like a real neighbour, so it moves just after the edge
    always @(posedge ref_clk) begin
        {carryIn, cascadeIn, logicEnable} <= #1 srst ? 3'h0 : nextLink;
    end
endmodule : lcc_neighbour_model

// ==== verification/lcc_cell_monitor.sv ====
// concurrent checks on the logic cell ports
`timescale 1ns/1ns
module lcc_cell_monitor
    import lcc_pkg::*;
(
    // clock, reset, configuration
    input wire logic ref_clk,
    input wire logic srst,
    input wire lcc_mode_type mode,
    input wire lcc_cpmode_type cpMode,
    input wire logic [15:0] lutTable,
    input wire lcc_outsel_type localSel,
    input wire lcc_outsel_type globalSel,
    input wire logic useCarryIn,
    input wire logic useCascade,
    input wire logic enableFromData,
    input wire logic chipResetEnable,
    input wire lcc_src_type clearSrc,
    input wire lcc_src_type presetSrc,
    input wire logic clearInvert,
    input wire logic presetInvert,
    // controls and data
    input wire logic globalClear,
    input wire logic globalPreset,
    input wire logic chipReset,
    input wire logic firstDataInput,
    input wire logic secondDataInput,
    input wire logic thirdDataInput,
    input wire logic fourthDataInput,
    input wire logic carryIn,
    input wire logic cascadeIn,
    // outputs
    input wire logic localOut,
    input wire logic globalOut,
    input wire logic carryOut,
    input wire logic cascadeOut,
    input wire logic regState
);
    logic [2:0] addIdx;
    logic plainCtl;
    logic quietCnt;
    assign addIdx = {carryIn, secondDataInput, firstDataInput};
    // every clear/preset kind is idle when both global controls are low
    assign quietCnt = clearSrc == SRC_GLOBAL && presetSrc == SRC_GLOBAL && !clearInvert
        && !presetInvert && !chipResetEnable && !globalClear && !globalPreset
        && enableFromData && firstDataInput;
    // only the plain global clear/preset path is judged here
    assign plainCtl = cpMode == CP_CLEAR_PRESET && clearSrc == SRC_GLOBAL
        && presetSrc == SRC_GLOBAL && !clearInvert && !presetInvert && !chipResetEnable;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_reset_zero_outputs: assert property (disable iff (1'b0) srst |=>
        !localOut && !globalOut && !carryOut && !cascadeOut && !regState)
        else $error("output set after reset");
    a_global_reg_mirror: assert property (
        $past(globalSel) == OUT_REG |-> globalOut == regState)
        else $error("global output differs from register");
    a_arith_carry_out: assert property (
        $past(!srst && mode == MODE_ARITH && useCarryIn) |->
        carryOut == $past(lutTable[{1'b1, addIdx}])) else $error("carry wrong");
    a_arith_sum_out: assert property (
        $past(!srst && mode == MODE_ARITH && useCarryIn && localSel == OUT_LUT && !useCascade)
        |-> localOut == $past(lutTable[{1'b0, addIdx}])) else $error("sum wrong");
    a_clear_forces_zero: assert property (
        $past(!srst && plainCtl && globalClear) |-> !regState) else $error("clear lost");
    a_preset_forces_one: assert property (
        $past(!srst && plainCtl && globalPreset && !globalClear) |-> regState)
        else $error("preset lost");
    a_enable_low_holds: assert property (
        !srst && plainCtl && !globalClear && !globalPreset && mode == MODE_NORMAL
        && enableFromData && !firstDataInput |=> $stable(regState))
        else $error("register moved while disabled");
    a_chip_reset_wins: assert property (
        (chipResetEnable && chipReset) ##2 chipResetEnable |=> !regState)
        else $error("chip reset ignored");
    a_count_sync_clear: assert property (
        $past(!srst && quietCnt && mode == MODE_CLRCNT && !cascadeIn) |-> !regState)
        else $error("counter clear lost");
    a_count_sync_load: assert property (
        $past(!srst && quietCnt && mode == MODE_UPDOWN && fourthDataInput) |->
        regState == $past(thirdDataInput)) else $error("counter load lost");
endmodule : lcc_cell_monitor
bind lcc_logic_cell lcc_cell_monitor lcc_cell_monitor_inst (.*);

// ==== verification/lcc_logic_cell_tb_top.sv ====
// self-checking bench for the logic cell with a neighbour model
`timescale 1ns/1ns
module lcc_logic_cell_tb_top
    import lcc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    lcc_mode_type mode = MODE_NORMAL;
    lcc_ff_type ffKind = FF_D;
    lcc_cpmode_type cpMode = CP_CLEAR_PRESET;
    lcc_outsel_type localSel = OUT_LUT;
    lcc_outsel_type globalSel = OUT_REG;
    lcc_src_type enableSrc = SRC_GLOBAL;
    logic [15:0] lutTable = 16'h0000;
    logic [3:0] din = 4'h0;
    logic [2:0] nextLink = 3'h0;
    logic [31:0] seed = 32'h0000005d;
    logic useCarryIn, useCascade, cascadeOr, enableFromData, chipResetEnable;
    logic globalClear, globalPreset, globalEnable, chipReset, regM;
    logic pinClear, pinPreset, pinEnable, logicClear, logicPreset;
    logic carryIn, cascadeIn, logicEnable;
    logic localOut, globalOut, carryOut, cascadeOut, regState;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    lcc_logic_cell lcc_logic_cell_inst (.*, .packedReg(1'b0), .clearSrc(SRC_GLOBAL),
        .presetSrc(SRC_GLOBAL), .clearInvert(1'b0), .presetInvert(1'b0),
        .firstDataInput(din[0]), .secondDataInput(din[1]), .thirdDataInput(din[2]),
        .fourthDataInput(din[3]));
    lcc_neighbour_model lcc_neighbour_model_inst (.*);
    always #10 ref_clk = ~ref_clk;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic check(input logic seen, input logic want);
        comparisons++;
        if (seen !== want) begin
            errors++;
            $display("[ERR] %0t output %b expected %b", $time, seen, want);
        end
    endtask : check
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    // random cycles against the integer model; chk picks which outputs count
    task automatic run(input int n, input logic [2:0] chk);
        logic [31:0] rv;
        logic lut, nreg, cas;
        int s;
        for (int i = 0; i < n; i++) begin
            rv = xs();
            din = rv[3:0];
            globalClear = rv[7:4] == 4'h0;
            globalPreset = rv[11:8] == 4'h0;
            {pinClear, pinPreset, pinEnable, logicClear, logicPreset} = rv[16:12];
            {globalEnable, chipReset, nextLink} = rv[21:17];
            enableSrc = (mode == MODE_ARITH) ? SRC_GLOBAL : (rv[22] ? SRC_PIN : SRC_LOGIC);
            s = din[0] + din[1] + carryIn;
            lut = (mode == MODE_ARITH) ? s[0] : lutTable[din];
            cas = !useCascade ? lut : (cascadeOr ? (lut | cascadeIn) : (lut & cascadeIn));
            case (ffKind)
                FF_D: nreg = cas;
                FF_T: nreg = cas ^ regM;
                FF_JK: nreg = (cas & !regM) | (!din[1] & regM);
                default: nreg = cas | (!din[1] & regM);
            endcase
            if (!(enableFromData ? din[0] : globalEnable)) nreg = regM;
            if (globalPreset) nreg = 1'b1;
            if (globalClear) nreg = 1'b0;
            @(posedge ref_clk);
            #2;
            regM = nreg;
            if (chk[0]) check(localOut, localSel == OUT_LUT ? lut : (localSel == OUT_CASCADE ? cas : nreg));
            if (chk[0]) check(globalOut, globalSel == OUT_LUT ? lut : nreg);
            if (chk[0]) check(regState, nreg);
            if (chk[1]) check(carryOut, s[1]);
            if (chk[2]) check(cascadeOut, cas);
        end
    endtask : run
    always @(posedge ref_clk) begin
        cycles++;
        // whole run needs about 490 cycles
        if (cycles > 3000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        {useCarryIn, useCascade, cascadeOr, chipResetEnable, regM} = 5'h00;
        {enableFromData, globalClear, globalPreset, globalEnable, chipReset} = 5'h10;
        {pinClear, pinPreset, pinEnable, logicClear, logicPreset} = 5'h00;
        repeat (10) @(posedge ref_clk);
        #2;
        srst = 1'b0;
        @(posedge ref_clk);
        #2;
        for (int k = 0; k < 4; k++) begin
            ffKind = lcc_ff_type'(k);
            lutTable = 16'(xs());
            localSel = k[0] ? OUT_REG : OUT_LUT;
            globalSel = k[0] ? OUT_LUT : OUT_REG;
            run(60, 3'b001);
        end
        mode = MODE_ARITH;
        {useCarryIn, enableFromData} = 2'b10;
        {localSel, globalSel, ffKind, lutTable} = {OUT_LUT, OUT_REG, FF_D, 16'he896};
        run(60, 3'b011);
        mode = MODE_NORMAL;
        {useCarryIn, useCascade, enableFromData} = 3'b011;
        localSel = OUT_CASCADE;
        for (int k = 0; k < 2; k++) begin
            cascadeOr = k[0];
            run(40, 3'b101);
        end
        // counter modes and clear/preset kinds are exercised, not modelled
        {useCascade, localSel} = {1'b0, OUT_LUT};
        for (int k = 0; k < 6; k++) begin
            mode = lcc_mode_type'(k % 4);
            cpMode = lcc_cpmode_type'(k);
            run(15, 3'b000);
        end
        srst = 1'b1;
        repeat (2) begin
            @(posedge ref_clk);
            #2;
            check(localOut | globalOut | carryOut | cascadeOut | regState, 1'b0);
        end
        {srst, mode, cpMode, ffKind} = {1'b0, MODE_NORMAL, CP_CLEAR_PRESET, FF_D};
        {lutTable, din, globalClear, globalPreset, chipReset} = {16'hffff, 4'h1, 3'h0};
        repeat (3) @(posedge ref_clk);
        #2;
        check(regState, 1'b1);
        {chipResetEnable, chipReset} = 2'b11;
        @(posedge ref_clk);
        #2;
        chipReset = 1'b0;
        // synchroniser delay: the register clears two edges on, then reloads
        repeat (2) @(posedge ref_clk);
        #2;
        check(regState, 1'b0);
        finish_test();
    end
endmodule : lcc_logic_cell_tb_top
